// ### core/vdic_controller.sv
`timescale 1ns/10ps
`default_nettype none
module vdic_controller (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic instr_request,
   input wire logic instr_request_type,
   input wire logic instr_burst_request,
   input wire logic data_request,
   input wire logic [1:0] data_request_type,
   input wire logic data_write,
   input wire logic [vdic_pkg::ADDR_HI_W-1:0] addr_hi,
   input wire logic addr_bit2,
   input wire logic test_takeover_input,
   input wire logic [vdic_pkg::WORD_W-1:0] mem_rdata,
   input wire logic rdata_ready,
   output logic instr_burst_ack,
   output logic instr_ready,
   output logic instr_out_en,
   output logic data_ready,
   output logic row_strobe,
   output logic col_strobe,
   output logic addr_mux_col,
   output logic write_strobe,
   output logic shift_run,
   output logic bank_sel,
   output logic refresh_active,
   output logic [vdic_pkg::WORD_W-1:0] rdata,
   output logic rdata_valid
);
   import vdic_pkg::*;

   // ****************************************
   // state
   // ****************************************
   typedef struct packed {
      vdic_rnd_t rnd;
      vdic_ser_t ser;
      logic pc_tail;
      logic refresh_ack;
      logic refresh_request_latch;
      logic [REFRESH_W-1:0] refresh_interval_count;
      logic back_d;
      logic write_op;
      logic ras;
      logic cas;
      logic addr_col;
      logic wstrobe;
      logic shift;
      logic bank;
      logic iready;
      logic ioe;
      logic dready;
      logic push;
      logic [WORD_W-1:0] word;
   } vdic_state_t;

   vdic_state_t st;
   vdic_state_t next_st;

   logic instr_block_select;
   logic data_block_select;
   logic instr_start;
   logic data_start;
   logic nothing_busy;
   logic ser_counting;
   logic preset_hit;
   logic burst_ack_now;

   vdic_stream_if #(.W(WORD_W)) fill_s ();
   vdic_stream_if #(.W(WORD_W)) drain_s ();

   function automatic logic vdic_ras_on(input vdic_rnd_t r);
      return (r == VDIC_R_INSTR_ROW) || (r == VDIC_R_INSTR_COL) || (r == VDIC_R_INSTR_WAIT)
         || (r == VDIC_R_DATA_ROW) || (r == VDIC_R_DATA_COL) || (r == VDIC_R_DATA_WAIT)
         || (r == VDIC_R_REFRESH_1) || (r == VDIC_R_REFRESH_2) || (r == VDIC_R_REFRESH_3);
   endfunction : vdic_ras_on

   // ****************************************
   // decode and start terms
   // ****************************************
   assign instr_block_select = instr_request && instr_request_type
      && (addr_hi == BLOCK_ADDR_HI) && !test_takeover_input;
   assign data_block_select = data_request && (data_request_type == DATA_SPACE_CODE)
      && (addr_hi == BLOCK_ADDR_HI) && !test_takeover_input;
   assign ser_counting = (st.ser != VDIC_S_IDLE) && (st.ser != VDIC_S_ACCESS);
   assign nothing_busy = (st.rnd == VDIC_R_IDLE) && !st.pc_tail && !st.refresh_ack
      && !st.refresh_request_latch;
   assign instr_start = nothing_busy && (st.ser == VDIC_S_IDLE) && instr_block_select;
   // data waits for room in the read buffer, so a stalled reader throttles accesses
   assign data_start = nothing_busy && !ser_counting && !instr_start && data_block_select
      && fill_s.ready;
   assign preset_hit = (st.refresh_interval_count == REFRESH_PRESET_AT);
   // outside serial wait 2, drops in the very cycle a new request shows, holding the address on the bus
   assign burst_ack_now = (st.ser == VDIC_S_WAIT_2) || (!instr_request && st.back_d);

   // ****************************************
   // next state
   // ****************************************
   always_comb begin
      next_st = st;
      next_st.push = 1'b0;
      next_st.pc_tail = (st.rnd == VDIC_R_PRECHARGE_2);
      next_st.back_d = burst_ack_now;

      // refresh interval and request latch; a preset wins over the clear
      if (preset_hit) begin
         next_st.refresh_interval_count = REFRESH_RESET_VALUE;
      end else begin
         next_st.refresh_interval_count = st.refresh_interval_count + 9'h001;
      end
      if (preset_hit) begin
         next_st.refresh_request_latch = 1'b1;
      end else if (st.rnd == VDIC_R_REFRESH_3) begin
         next_st.refresh_request_latch = 1'b0;
      end

      if (st.refresh_ack && st.rnd == VDIC_R_REFRESH_3) begin
         next_st.refresh_ack = 1'b0;
      end else if ((st.rnd == VDIC_R_IDLE) && !st.pc_tail && !ser_counting
                   && st.refresh_request_latch) begin
         next_st.refresh_ack = 1'b1;
      end

      // random-port tracker
      case (st.rnd)
         VDIC_R_IDLE: begin
            if (st.refresh_ack) begin
               next_st.rnd = VDIC_R_REFRESH_1;
            end else if (instr_start) begin
               next_st.rnd = VDIC_R_INSTR_ROW;
            end else if (data_start) begin
               next_st.rnd = VDIC_R_DATA_ROW;
               next_st.write_op = data_write;
            end
         end
         VDIC_R_INSTR_ROW: next_st.rnd = VDIC_R_INSTR_COL;
         VDIC_R_INSTR_COL: next_st.rnd = VDIC_R_INSTR_WAIT;
         VDIC_R_INSTR_WAIT: next_st.rnd = VDIC_R_PRECHARGE_1;
         VDIC_R_DATA_ROW: next_st.rnd = VDIC_R_DATA_COL;
         VDIC_R_DATA_COL: next_st.rnd = VDIC_R_DATA_WAIT;
         VDIC_R_DATA_WAIT: next_st.rnd = VDIC_R_DATA_ACCESS;
         VDIC_R_DATA_ACCESS: begin
            next_st.rnd = VDIC_R_PRECHARGE_1;
            if (!st.write_op) begin
               next_st.push = 1'b1;
               next_st.word = mem_rdata;
            end
         end
         VDIC_R_REFRESH_1: next_st.rnd = VDIC_R_REFRESH_2;
         VDIC_R_REFRESH_2: next_st.rnd = VDIC_R_REFRESH_3;
         VDIC_R_REFRESH_3: next_st.rnd = VDIC_R_PRECHARGE_1;
         VDIC_R_PRECHARGE_1: next_st.rnd = VDIC_R_PRECHARGE_2;
         VDIC_R_PRECHARGE_2: next_st.rnd = VDIC_R_IDLE;
         default: next_st.rnd = VDIC_R_IDLE;
      endcase

      // serial-port tracker
      case (st.ser)
         VDIC_S_IDLE: begin
            if (instr_start) begin
               next_st.ser = VDIC_S_WAIT_1;
            end
         end
         VDIC_S_WAIT_1: next_st.ser = VDIC_S_WAIT_2;
         VDIC_S_WAIT_2: next_st.ser = VDIC_S_WAIT_3;
         VDIC_S_WAIT_3: next_st.ser = VDIC_S_WAIT_4;
         VDIC_S_WAIT_4: next_st.ser = VDIC_S_ACCESS;
         VDIC_S_ACCESS: begin
            // random tracker is untouched here, so data and refresh run meanwhile
            if (!instr_burst_request) begin
               next_st.ser = VDIC_S_IDLE;
            end
         end
         default: next_st.ser = VDIC_S_IDLE;
      endcase

      // registered outputs follow the state they belong to
      next_st.ras = vdic_ras_on(next_st.rnd);
      next_st.cas = (next_st.rnd == VDIC_R_INSTR_COL) || (next_st.rnd == VDIC_R_INSTR_WAIT)
         || (next_st.rnd == VDIC_R_DATA_COL) || (next_st.rnd == VDIC_R_DATA_WAIT)
         || (next_st.rnd == VDIC_R_DATA_ACCESS && !next_st.write_op)
         || (next_st.refresh_ack && (next_st.rnd == VDIC_R_IDLE))
         || (next_st.rnd == VDIC_R_REFRESH_1) || (next_st.rnd == VDIC_R_REFRESH_2)
         || (next_st.rnd == VDIC_R_REFRESH_3);
      // a one-cycle delay stands in for the delay line after row strobe
      next_st.addr_col = st.ras && (st.rnd != VDIC_R_IDLE) && vdic_ras_on(next_st.rnd)
         && (next_st.rnd != VDIC_R_REFRESH_2) && (next_st.rnd != VDIC_R_REFRESH_3);
      next_st.wstrobe = next_st.write_op && (next_st.rnd == VDIC_R_DATA_COL);
      next_st.dready = (next_st.rnd == VDIC_R_DATA_COL && next_st.write_op)
         || (next_st.rnd == VDIC_R_DATA_ACCESS && !next_st.write_op);
      next_st.shift = (next_st.ser == VDIC_S_WAIT_3) || (next_st.ser == VDIC_S_WAIT_4)
         || (next_st.ser == VDIC_S_ACCESS);
      next_st.iready = (next_st.ser == VDIC_S_ACCESS);
      next_st.ioe = (next_st.ser == VDIC_S_ACCESS);
      if (instr_start) begin
         next_st.bank = addr_bit2;
      end else if (st.shift) begin
         next_st.bank = !st.bank;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   // ****************************************
   // read buffer
   // ****************************************
   assign fill_s.valid = st.push;
   assign fill_s.data = st.word;
   assign drain_s.ready = rdata_ready;

   vdic_skid_buffer #(.W(WORD_W)) u_rbuf (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .in_s(fill_s),
      .out_s(drain_s)
   );

   // ****************************************
   // outputs
   // ****************************************
   // burst ack must react to the request inside the cycle, so it is not a flop
   assign instr_burst_ack = burst_ack_now;
   assign instr_ready = st.iready;
   assign instr_out_en = st.ioe;
   assign data_ready = st.dready;
   assign row_strobe = st.ras;
   assign col_strobe = st.cas;
   assign addr_mux_col = st.addr_col;
   assign write_strobe = st.wstrobe;
   assign shift_run = st.shift;
   assign bank_sel = st.bank;
   assign refresh_active = st.refresh_ack;
   assign rdata = drain_s.data;
   assign rdata_valid = drain_s.valid;

   // ****************************************
   // checks
   // ****************************************
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   sequence instr_path;
      st.rnd == VDIC_R_INSTR_COL ##1 st.rnd == VDIC_R_INSTR_WAIT
      ##1 st.rnd == VDIC_R_PRECHARGE_1 ##1 st.rnd == VDIC_R_PRECHARGE_2;
   endsequence
   sequence read_path;
      st.rnd == VDIC_R_DATA_COL ##1 st.rnd == VDIC_R_DATA_WAIT
      ##1 (st.rnd == VDIC_R_DATA_ACCESS && data_ready);
   endsequence

   a_serial_leave: assert property ((st.ser == VDIC_S_WAIT_1 && $past(st.ser) == VDIC_S_IDLE)
      |-> $past(st.rnd) == VDIC_R_IDLE) else $error("serial left idle while busy");
   a_instr_path: assert property (st.rnd == VDIC_R_INSTR_ROW |-> st.ser == VDIC_S_WAIT_1
      && row_strobe && !instr_ready ##1 instr_path) else $error("bad instr path");
   a_ack_wait2: assert property (st.ser == VDIC_S_WAIT_2 |-> instr_burst_ack)
      else $error("no burst ack in wait 2");
   a_ready_access: assert property (instr_ready |-> st.ser == VDIC_S_ACCESS
      && $past(shift_run, 2)) else $error("early instr ready");
   a_mux_delay: assert property ($rose(row_strobe) && st.rnd != VDIC_R_REFRESH_1
      |-> !addr_mux_col ##1 addr_mux_col) else $error("mux switch timing");
   a_precharge_low: assert property (st.rnd == VDIC_R_PRECHARGE_1 |-> !row_strobe [*3])
      else $error("precharge too short");
   a_read_path: assert property (st.rnd == VDIC_R_DATA_ROW && !st.write_op |=> read_path)
      else $error("bad read path");
   a_write_ready: assert property (st.rnd == VDIC_R_DATA_COL && st.write_op |-> data_ready
      ##3 st.rnd == VDIC_R_PRECHARGE_1) else $error("write ready missing");
   a_refresh_first: assert property (st.rnd == VDIC_R_IDLE && st.refresh_ack
      |-> col_strobe ##1 st.rnd == VDIC_R_REFRESH_1) else $error("refresh not first");
   a_refresh_ras: assert property (st.rnd == VDIC_R_REFRESH_1 |-> row_strobe [*3]
      ##1 !row_strobe) else $error("refresh row strobe width");
   a_refresh_preset: assert property (preset_hit |=> st.refresh_interval_count == 9'h000
      && st.refresh_request_latch) else $error("refresh preset wrong");
   a_latch_hold: assert property (st.refresh_request_latch && st.rnd != VDIC_R_REFRESH_3
      |=> st.refresh_request_latch) else $error("latch lost");
   a_ack_drop: assert property (instr_request && st.ser != VDIC_S_WAIT_2
      |-> !instr_burst_ack) else $error("burst ack held over request");

   // ****************************************
   // checks on refresh, starts and burst end
   // ****************************************
   a_random_free: assert property (st.ser == VDIC_S_ACCESS && data_start
      |=> st.rnd == VDIC_R_DATA_ROW) else $error("data blocked by serial");
   a_burst_end: assert property (st.ser == VDIC_S_ACCESS && !instr_burst_request
      |=> st.ser == VDIC_S_IDLE) else $error("burst did not end");
   a_ack_set: assert property (st.rnd == VDIC_R_IDLE && !st.pc_tail && !ser_counting
      && st.refresh_request_latch && !st.refresh_ack |=> refresh_active)
      else $error("refresh ack not raised");
   a_ack_clear: assert property (st.rnd == VDIC_R_REFRESH_3 && st.refresh_ack
      |=> !refresh_active) else $error("refresh ack not cleared");
   a_refresh_flag: assert property ($rose(st.rnd == VDIC_R_REFRESH_1)
      |-> $past(st.rnd) == VDIC_R_IDLE) else $error("refresh began outside idle");
   a_data_select: assert property ($rose(st.rnd == VDIC_R_DATA_ROW)
      |-> $past(data_block_select)) else $error("data access not selected");
   a_start_idle: assert property (instr_start || data_start |-> st.rnd == VDIC_R_IDLE
      && !st.pc_tail && !st.refresh_request_latch) else $error("start while busy");
endmodule : vdic_controller
`default_nettype wire

// ### core/vdic_pkg.sv
package vdic_pkg;
   localparam int CLK_PERIOD_NS = 40;
   localparam int RAS_MIN_NS = 120;
   localparam int CAS_MIN_NS = 60;
   localparam int PRECHARGE_NS = 100;
   localparam int RAS_MIN_CYC = (RAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CAS_MIN_CYC = (CAS_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int PRECHARGE_CYC = (PRECHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int REFRESH_W = 9;
   localparam logic [8:0] REFRESH_PRESET_AT = 9'h185;
   localparam logic [8:0] REFRESH_RESET_VALUE = 9'h000;
   localparam int ADDR_HI_W = 9;
   localparam logic [8:0] BLOCK_ADDR_HI = 9'h000;
   localparam logic [1:0] DATA_SPACE_CODE = 2'h0;
   localparam int WORD_W = 32;

   typedef enum logic [3:0] {
      VDIC_R_IDLE = 4'h0,
      VDIC_R_INSTR_ROW = 4'h1,
      VDIC_R_INSTR_COL = 4'h3,
      VDIC_R_INSTR_WAIT = 4'h2,
      VDIC_R_PRECHARGE_1 = 4'h6,
      VDIC_R_PRECHARGE_2 = 4'h7,
      VDIC_R_DATA_ROW = 4'h4,
      VDIC_R_DATA_COL = 4'hc,
      VDIC_R_DATA_WAIT = 4'hd,
      VDIC_R_DATA_ACCESS = 4'hf,
      VDIC_R_REFRESH_1 = 4'h8,
      VDIC_R_REFRESH_2 = 4'h9,
      VDIC_R_REFRESH_3 = 4'hb
   } vdic_rnd_t;

   typedef enum logic [2:0] {
      VDIC_S_IDLE = 3'h0,
      VDIC_S_WAIT_1 = 3'h1,
      VDIC_S_WAIT_2 = 3'h3,
      VDIC_S_WAIT_3 = 3'h2,
      VDIC_S_WAIT_4 = 3'h6,
      VDIC_S_ACCESS = 3'h7
   } vdic_ser_t;
endpackage : vdic_pkg

// ### core/vdic_stream_if.sv
`timescale 1ns/10ps
`default_nettype none
interface vdic_stream_if #(parameter int W = 32);
   logic [W-1:0] data;
   logic valid;
   logic ready;
   modport src (output data, output valid, input ready);
   modport snk (input data, input valid, output ready);
endinterface : vdic_stream_if
`default_nettype wire

// ### core/vdic_skid_buffer.sv
`timescale 1ns/10ps
`default_nettype none
module vdic_skid_buffer #(
   parameter int W = 32
) (
   input wire logic core_clk,
   input wire logic rst_b,
   vdic_stream_if.snk in_s,
   vdic_stream_if.src out_s
);
   import vdic_pkg::*;

   typedef struct packed {
      logic [1:0] count;
      logic [W-1:0] slot0;
      logic [W-1:0] slot1;
      logic has_room;
      logic has_word;
   } vdic_buf_t;

   vdic_buf_t st;
   vdic_buf_t next_st;
   logic push;
   logic pop;

   assign push = in_s.valid && st.has_room;
   assign pop = st.has_word && out_s.ready;

   always_comb begin
      next_st = st;
      if (pop) begin
         next_st.slot0 = st.slot1;
      end
      if (push) begin
         if ((st.count == 2'h0) || (st.count == 2'h1 && pop)) begin
            next_st.slot0 = in_s.data;
         end else begin
            next_st.slot1 = in_s.data;
         end
      end
      next_st.count = st.count + {1'b0, push} - {1'b0, pop};
      next_st.has_room = (next_st.count != 2'h2);
      next_st.has_word = (next_st.count != 2'h0);
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st <= '{count: 2'h0, slot0: '0, slot1: '0, has_room: 1'b1, has_word: 1'b0};
      end else begin
         st <= next_st;
      end
   end

   assign in_s.ready = st.has_room;
   assign out_s.valid = st.has_word;
   assign out_s.data = st.slot0;
endmodule : vdic_skid_buffer
`default_nettype wire

// ### bench/vdic_cpu_model.sv
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// far side: memory read data and downstream word sink
// ****************************************************************
module vdic_cpu_model (
   input wire logic core_clk,
   input wire logic rst_b,
   input wire logic col_strobe,
   input wire logic stall,
   input wire logic [vdic_pkg::WORD_W-1:0] word,
   output logic [vdic_pkg::WORD_W-1:0] mem_rdata,
   output logic rdata_ready
);
   import vdic_pkg::*;
   logic [WORD_W-1:0] churn;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         churn <= 32'h0;
      end else begin
         churn <= churn + 32'h1;
      end
   end
   // lines float when column strobe is off; a moving pattern keeps a stray capture from passing
   assign mem_rdata = col_strobe ? word : (~word ^ churn);
   assign rdata_ready = ~stall;
endmodule : vdic_cpu_model
`default_nettype wire

// ### bench/vdic_controller_bench.sv
`timescale 1ns/10ps
`default_nettype none
module vdic_controller_bench;
   import vdic_pkg::*;
   logic core_clk = 1'b0;
   logic rst_b = 1'b0;
   logic instr_request = 1'b0;
   logic instr_request_type = 1'b1;
   logic instr_burst_request = 1'b0;
   logic data_request = 1'b0;
   logic [1:0] data_request_type = DATA_SPACE_CODE;
   logic data_write = 1'b0;
   logic [ADDR_HI_W-1:0] addr_hi = BLOCK_ADDR_HI;
   logic addr_bit2 = 1'b0;
   logic test_takeover_input = 1'b0;
   logic stall = 1'b0;
   logic [WORD_W-1:0] word = 32'h0;
   logic [WORD_W-1:0] mem_rdata, rdata;
   logic rdata_ready, instr_burst_ack, instr_ready, instr_out_en, data_ready, row_strobe;
   logic col_strobe, addr_mux_col, write_strobe, shift_run, bank_sel, refresh_active;
   logic rdata_valid;
   int mismatches = 0;
   int samples_checked = 0;

   vdic_controller i_vdic_controller (.core_clk(core_clk), .rst_b(rst_b),
      .instr_request(instr_request), .instr_request_type(instr_request_type),
      .instr_burst_request(instr_burst_request), .data_request(data_request),
      .data_request_type(data_request_type), .data_write(data_write), .addr_hi(addr_hi),
      .addr_bit2(addr_bit2), .test_takeover_input(test_takeover_input),
      .mem_rdata(mem_rdata), .rdata_ready(rdata_ready), .instr_burst_ack(instr_burst_ack),
      .instr_ready(instr_ready), .instr_out_en(instr_out_en), .data_ready(data_ready),
      .row_strobe(row_strobe), .col_strobe(col_strobe), .addr_mux_col(addr_mux_col),
      .write_strobe(write_strobe), .shift_run(shift_run), .bank_sel(bank_sel),
      .refresh_active(refresh_active), .rdata(rdata), .rdata_valid(rdata_valid));

   vdic_cpu_model i_vdic_cpu_model (.core_clk(core_clk), .rst_b(rst_b),
      .col_strobe(col_strobe), .stall(stall), .word(word), .mem_rdata(mem_rdata),
      .rdata_ready(rdata_ready));

   initial begin
      forever #20 core_clk = ~core_clk;
   end

   // ****************************************************************
   // shared tasks
   // ****************************************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : give_verdict

   // cyc counts cycles from the request to data_ready; ws is write_strobe in that cycle
   task automatic data_op(input logic w, output int cyc, output logic ws);
      cyc = 0;
      repeat (3) @(posedge core_clk);
      data_request <= 1'b1;
      data_write <= w;
      @(negedge core_clk);
      while (data_ready !== 1'b1 && cyc < 40) begin
         @(negedge core_clk);
         cyc++;
      end
      ws = write_strobe;
      @(posedge core_clk);
      data_request <= 1'b0;
   endtask : data_op

   // a refresh just done leaves some 380 cycles in which timing walks are undisturbed
   task automatic sync_refresh;
      int n;
      n = 0;
      while (refresh_active !== 1'b1 && n < 1000) begin
         @(negedge core_clk);
         n++;
      end
      while (refresh_active === 1'b1 && n < 1000) begin
         @(negedge core_clk);
         n++;
      end
      repeat (6) @(negedge core_clk);
   endtask : sync_refresh

   // ****************************************************************
   // scenarios
   // ****************************************************************
   task automatic test_reset;
      check({instr_burst_ack, instr_ready, instr_out_en, data_ready, row_strobe, col_strobe,
         addr_mux_col, write_strobe, shift_run, bank_sel, refresh_active, rdata_valid},
         32'h0);
   endtask : test_reset

   task automatic test_refresh;
      int n;
      logic prev;
      n = 0;
      @(posedge core_clk);
      while (refresh_active !== 1'b1 && n < 500) begin
         @(negedge core_clk);
         n++;
      end
      check(n, 32'd391);
      check({col_strobe, row_strobe}, 2'b10);
      repeat (3) begin
         @(negedge core_clk);
         check(row_strobe, 1'b1);
      end
      @(negedge core_clk);
      check(row_strobe, 1'b0);
      n = 4;
      do begin
         prev = refresh_active;
         @(negedge core_clk);
         n++;
      end while (!(refresh_active === 1'b1 && prev !== 1'b1) && n < 1000);
      check(n, 32'd390);
   endtask : test_refresh

   task automatic test_instr;
      logic [6:0] row, col, ack, sh, rdy, oe, bk, mx;
      int cyc;
      logic ws;
      sync_refresh;
      @(posedge core_clk);
      instr_request <= 1'b1;
      instr_burst_request <= 1'b1;
      addr_bit2 <= 1'b1;
      word <= 32'h5a5a_0f0f;
      for (int k = 0; k < 7; k++) begin
         @(negedge core_clk);
         row[k] = row_strobe;
         col[k] = col_strobe;
         ack[k] = instr_burst_ack;
         sh[k] = shift_run;
         rdy[k] = instr_ready;
         oe[k] = instr_out_en;
         bk[k] = bank_sel;
         mx[k] = addr_mux_col;
         if (k == 1) begin
            @(posedge core_clk);
            instr_request <= 1'b0;
         end
      end
      check(row[1], 1'b1);
      check({rdy[1], oe[1]}, 2'b00);
      check({col[2], ack[1], ack[2]}, 3'b101);
      check({mx[1], mx[2]}, 2'b01);
      check({sh[2], sh[3], bk[3], bk[4]}, 4'b0110);
      check({rdy[4], rdy[5], oe[5]}, 3'b011);
      check({row[4], row[5], row[6]}, 3'b000);
      data_op(1'b0, cyc, ws);
      check(cyc, 32'd4);
      @(negedge core_clk);
      check({instr_ready, instr_burst_ack}, 2'b11);
      @(posedge core_clk);
      instr_request <= 1'b1;
      addr_hi <= 9'h1ff;
      @(negedge core_clk);
      check(instr_burst_ack, 1'b0);
      @(posedge core_clk);
      instr_request <= 1'b0;
      instr_burst_request <= 1'b0;
      addr_hi <= BLOCK_ADDR_HI;
      repeat (2) @(negedge core_clk);
      check({instr_ready, instr_burst_ack}, 2'b00);
   endtask : test_instr

   task automatic test_buffer;
      int cyc;
      logic ws, seen;
      logic [31:0] q[$];
      sync_refresh;
      @(posedge core_clk);
      stall <= 1'b1;
      word <= 32'ha5a5_0001;
      data_op(1'b0, cyc, ws);
      check(cyc, 32'd4);
      word <= 32'ha5a5_0002;
      data_op(1'b0, cyc, ws);
      @(negedge core_clk);
      check({rdata_valid, rdata[30:0]}, {1'b1, 31'h25a5_0001});
      @(posedge core_clk);
      word <= 32'ha5a5_0003;
      data_request <= 1'b1;
      seen = 1'b0;
      repeat (10) begin
         @(negedge core_clk);
         seen |= row_strobe;
      end
      check(seen, 1'b0);
      @(posedge core_clk);
      stall <= 1'b0;
      repeat (30) begin
         @(negedge core_clk);
         if (rdata_valid === 1'b1 && rdata_ready === 1'b1) q.push_back(rdata);
         if (data_ready === 1'b1) begin
            @(posedge core_clk);
            data_request <= 1'b0;
         end
      end
      check(q.size(), 32'd3);
      for (int i = 0; i < 3; i++) begin
         check(q[i], 32'ha5a5_0001 + i);
      end
   endtask : test_buffer

   task automatic test_select;
      int cyc;
      logic ws, seen;
      sync_refresh;
      for (int i = 0; i < 4; i++) begin
         @(posedge core_clk);
         addr_hi <= (i == 0) ? 9'h100 : (i == 1) ? 9'h001 : BLOCK_ADDR_HI;
         test_takeover_input <= (i == 2);
         instr_request_type <= (i != 3);
         data_request_type <= (i == 3) ? 2'h1 : DATA_SPACE_CODE;
         instr_request <= 1'b1;
         data_request <= 1'b1;
         seen = 1'b0;
         repeat (10) begin
            @(negedge core_clk);
            seen |= row_strobe | instr_burst_ack | data_ready;
         end
         check(seen, 1'b0);
      end
      @(posedge core_clk);
      addr_hi <= BLOCK_ADDR_HI;
      test_takeover_input <= 1'b0;
      instr_request_type <= 1'b1;
      data_request_type <= DATA_SPACE_CODE;
      instr_request <= 1'b0;
      data_request <= 1'b0;
      data_op(1'b1, cyc, ws);
      check(cyc, 32'd2);
      check(ws, 1'b1);
   endtask : test_select

   initial begin
      repeat (11) @(posedge core_clk);
      test_reset;
      @(posedge core_clk);
      rst_b <= 1'b1;
      test_refresh;
      test_instr;
      test_buffer;
      test_select;
      give_verdict;
   end

   // the scenarios need some 1,650 cycles; 8,000 leaves ample margin
   initial begin
      #320000;
      mismatches++;
      give_verdict;
   end
endmodule : vdic_controller_bench
`default_nettype wire
